// >>> logic/lst_ctrl.sv
// Register file, slot sequencer and die temperature control
`timescale 1ns/1ns
module lst_ctrl #(
	parameter int TEMP_CYCLES = lst_pkg::TEMP_CONV_CYCLES,
	parameter int SLOT_CYCLES = lst_pkg::SLOT_CYCLES,
	parameter int FIFO_DEPTH = lst_pkg::FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic regWrite,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWriteData,
	output logic [7:0] regReadData,
	input wire logic sampleStart,
	input wire logic [23:0] adcResult,
	input wire logic [15:0] tempSensorCode,
	output logic [7:0] redDriveLevel,
	output logic [7:0] infraredDriveLevel,
	output logic [7:0] greenADriveLevel,
	output logic [7:0] greenBDriveLevel,
	output logic [15:0] redCurrentUa,
	output logic [4:0] adcResolution,
	output logic slotBusy,
	output logic tempReady,
	output logic [23:0] resultData,
	output logic resultValid,
	input wire logic resultReady
);
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_PULSE, SEQ_PUSH} lst_seq_t;
	logic [7:0] redLevel_reg;
	logic [7:0] irLevel_reg;
	logic [7:0] greenALevel_reg;
	logic [7:0] greenBLevel_reg;
	logic [7:0] slotLow_reg;
	logic [7:0] slotHigh_reg;
	logic [7:0] tempWhole_reg;
	logic [3:0] tempSixteenths_reg;
	logic tempEnable_reg;
	logic [2:0] modeSelect_reg;
	logic [2:0] sampleRateSelect_reg;
	logic [1:0] pulseWidthSelect_reg;
	logic tempDone_reg;
	logic [$clog2(TEMP_CYCLES+1)-1:0] tempCount_reg;
	lst_seq_t seq_reg;
	logic [1:0] slotIdx_reg;
	logic [$clog2(SLOT_CYCLES+1)-1:0] slotCount_reg;
	logic [23:0] captured_reg;
	lst_stream_if #(.WIDTH(lst_pkg::RESULT_W)) pushIf ();
	lst_stream_if #(.WIDTH(lst_pkg::RESULT_W)) pullIf ();
	wire [2:0] slotSel [4];
	wire [2:0] curSel;
	wire curEnabled;
	wire lastSlot;
	wire multiMode;
	wire [2:0] rateCap;
	wire [2:0] requestedRate;
	wire [2:0] storedRate;
	wire [7:0] tempPartRead;
	wire [7:0] sampleCfgRead;

	////////////////////////////////////////////////////////////////////////
	// Slot selector fields of the two slot registers
	assign slotSel[0] = slotLow_reg[lst_pkg::SLOT_LO_POS +: 3];
	assign slotSel[1] = slotLow_reg[lst_pkg::SLOT_HI_POS +: 3];
	assign slotSel[2] = slotHigh_reg[lst_pkg::SLOT_LO_POS +: 3];
	assign slotSel[3] = slotHigh_reg[lst_pkg::SLOT_HI_POS +: 3];
	assign curSel = slotSel[slotIdx_reg];
	assign curEnabled = (curSel != lst_pkg::SEL_OFF);
	assign lastSlot = (slotIdx_reg == 2'h3);
	assign multiMode = (modeSelect_reg == lst_pkg::MODE_MULTI);

	////////////////////////////////////////////////////////////////////////
	// Drive levels routed per selector; green sinks both of its channels
	assign redDriveLevel = (slotBusy && curSel == lst_pkg::SEL_RED) ? redLevel_reg : 8'h00;
	assign infraredDriveLevel = (slotBusy && curSel == lst_pkg::SEL_IR) ? irLevel_reg : 8'h00;
	assign greenADriveLevel = (slotBusy && curSel == lst_pkg::SEL_GREEN) ? greenALevel_reg : 8'h00;
	assign greenBDriveLevel = (slotBusy && curSel == lst_pkg::SEL_GREEN) ? greenBLevel_reg : 8'h00;
	// Codes 100 and reserved ones fall through to zero, so no LED runs
	assign redCurrentUa = 16'(redLevel_reg * lst_pkg::DRIVE_STEP_UA);
	// A disabled slot passes through PULSE for one cycle but must not look like a pulse
	assign slotBusy = (seq_reg == SEQ_PULSE) && curEnabled;

	////////////////////////////////////////////////////////////////////////
	// Rate capping by pulse width; the write stores the cap when too high
	assign requestedRate = regWriteData[lst_pkg::RATE_POS +: 3];
	assign rateCap = (modeSelect_reg == lst_pkg::MODE_HEART) ? lst_pkg::HR_MAX_RATE[pulseWidthSelect_reg]
		: lst_pkg::SPO2_MAX_RATE[pulseWidthSelect_reg];
	assign storedRate = (requestedRate > rateCap) ? rateCap : requestedRate;
	assign adcResolution = lst_pkg::BASE_RESOLUTION + 5'(pulseWidthSelect_reg);

	////////////////////////////////////////////////////////////////////////
	// Read multiplexer; unmapped offsets read zero
	assign tempPartRead = {4'h0, tempSixteenths_reg};
	assign sampleCfgRead = {3'h0, sampleRateSelect_reg, pulseWidthSelect_reg};
	always_comb
	begin
		unique case (regAddr)
			lst_pkg::ADDR_RED_LEVEL: regReadData = redLevel_reg;
			lst_pkg::ADDR_IR_LEVEL: regReadData = irLevel_reg;
			lst_pkg::ADDR_GREEN_A_LEVEL: regReadData = greenALevel_reg;
			lst_pkg::ADDR_GREEN_B_LEVEL: regReadData = greenBLevel_reg;
			lst_pkg::ADDR_SLOT_LOW: regReadData = slotLow_reg & 8'h77;
			lst_pkg::ADDR_SLOT_HIGH: regReadData = slotHigh_reg & 8'h77;
			lst_pkg::ADDR_TEMP_WHOLE: regReadData = tempWhole_reg;
			lst_pkg::ADDR_TEMP_PART: regReadData = tempPartRead;
			lst_pkg::ADDR_TEMP_TRIG: regReadData = {7'h00, tempEnable_reg};
			lst_pkg::ADDR_MODE_CFG: regReadData = {5'h00, modeSelect_reg};
			lst_pkg::ADDR_SAMPLE_CFG: regReadData = sampleCfgRead;
			default: regReadData = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers written by the host
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			redLevel_reg <= lst_pkg::RESET_BYTE;
			irLevel_reg <= lst_pkg::RESET_BYTE;
			greenALevel_reg <= lst_pkg::RESET_BYTE;
			greenBLevel_reg <= lst_pkg::RESET_BYTE;
			slotLow_reg <= lst_pkg::RESET_BYTE;
			slotHigh_reg <= lst_pkg::RESET_BYTE;
			modeSelect_reg <= 3'h0;
			sampleRateSelect_reg <= 3'h0;
			pulseWidthSelect_reg <= 2'h0;
		end
		else if (regWrite)
		begin
			unique case (regAddr)
				lst_pkg::ADDR_RED_LEVEL: redLevel_reg <= regWriteData;
				lst_pkg::ADDR_IR_LEVEL: irLevel_reg <= regWriteData;
				lst_pkg::ADDR_GREEN_A_LEVEL: greenALevel_reg <= regWriteData;
				lst_pkg::ADDR_GREEN_B_LEVEL: greenBLevel_reg <= regWriteData;
				lst_pkg::ADDR_SLOT_LOW: slotLow_reg <= regWriteData;
				lst_pkg::ADDR_SLOT_HIGH: slotHigh_reg <= regWriteData;
				lst_pkg::ADDR_MODE_CFG: modeSelect_reg <= regWriteData[2:0];
				lst_pkg::ADDR_SAMPLE_CFG:
				begin
					sampleRateSelect_reg <= storedRate;
					pulseWidthSelect_reg <= regWriteData[lst_pkg::WIDTH_POS +: 2];
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Die temperature: one conversion per enable write, then self-clear
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			tempEnable_reg <= 1'b0;
			tempCount_reg <= '0;
			tempWhole_reg <= lst_pkg::RESET_BYTE;
			tempSixteenths_reg <= 4'h0;
			tempDone_reg <= 1'b0;
		end
		else
		begin
			tempDone_reg <= 1'b0;
			if (tempEnable_reg)
			begin
				if (tempCount_reg == '0)
				begin
					// Sensor code: bits 11:4 whole degrees, then bits 3:0 sixteenths
					tempWhole_reg <= tempSensorCode[11:4];
					tempSixteenths_reg <= tempSensorCode[3:0];
					tempEnable_reg <= 1'b0;
					tempDone_reg <= 1'b1;
				end
				else
					tempCount_reg <= tempCount_reg - 1'b1;
			end
			else if (regWrite && regAddr == lst_pkg::ADDR_TEMP_TRIG
				&& regWriteData[lst_pkg::TRIG_POS])
			begin
				tempEnable_reg <= 1'b1;
				tempCount_reg <= ($clog2(TEMP_CYCLES+1))'(TEMP_CYCLES - 1);
			end
			else if (regWrite && regAddr == lst_pkg::ADDR_TEMP_WHOLE)
				tempWhole_reg <= regWriteData;
			else if (regWrite && regAddr == lst_pkg::ADDR_TEMP_PART)
				tempSixteenths_reg <= regWriteData[3:0];
		end
	end
	assign tempReady = tempDone_reg;

	////////////////////////////////////////////////////////////////////////
	// Slot sequencer: walks slots one to four, pushing one result per enabled slot
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			seq_reg <= SEQ_IDLE;
			slotIdx_reg <= 2'h0;
			slotCount_reg <= '0;
			captured_reg <= 24'h000000;
		end
		else
		begin
			unique case (seq_reg)
				SEQ_IDLE:
					if (sampleStart && multiMode)
					begin
						slotIdx_reg <= 2'h0;
						slotCount_reg <= ($clog2(SLOT_CYCLES+1))'(SLOT_CYCLES - 1);
						seq_reg <= SEQ_PULSE;
					end
				SEQ_PULSE:
					if (!curEnabled)
					begin
						// Disabled slot adds no bytes to the sample
						seq_reg <= lastSlot ? SEQ_IDLE : SEQ_PULSE;
						slotIdx_reg <= slotIdx_reg + 2'h1;
						slotCount_reg <= ($clog2(SLOT_CYCLES+1))'(SLOT_CYCLES - 1);
					end
					else if (slotCount_reg == '0)
					begin
						captured_reg <= adcResult;
						seq_reg <= SEQ_PUSH;
					end
					else
						slotCount_reg <= slotCount_reg - 1'b1;
				SEQ_PUSH:
					// Waits here while the FIFO is full, so no result is dropped
					if (pushIf.ready)
					begin
						seq_reg <= lastSlot ? SEQ_IDLE : SEQ_PULSE;
						slotIdx_reg <= slotIdx_reg + 2'h1;
						slotCount_reg <= ($clog2(SLOT_CYCLES+1))'(SLOT_CYCLES - 1);
					end
				default: seq_reg <= SEQ_IDLE;
			endcase
		end
	end
	assign pushIf.valid = (seq_reg == SEQ_PUSH);
	assign pushIf.data = captured_reg;

	////////////////////////////////////////////////////////////////////////
	// Result FIFO toward the reader
	lst_fifo #(
		.WIDTH(lst_pkg::RESULT_W),
		.DEPTH(FIFO_DEPTH)
	) resultFifo (
		.clk_sys(clk_sys),
		.srst(srst),
		.inSide(pushIf.sink),
		.outSide(pullIf.source)
	);
	assign resultValid = pullIf.valid;
	assign resultData = pullIf.data;
	assign pullIf.ready = resultReady;
endmodule : lst_ctrl

// >>> logic/lst_pkg.sv
// Package of register offsets, field layouts and codes for the LED slot and die temperature block
package lst_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_RED_LEVEL = 8'h0c;
	localparam logic [7:0] ADDR_IR_LEVEL = 8'h0d;
	localparam logic [7:0] ADDR_GREEN_A_LEVEL = 8'h0e;
	localparam logic [7:0] ADDR_GREEN_B_LEVEL = 8'h0f;
	localparam logic [7:0] ADDR_SLOT_LOW = 8'h11;
	localparam logic [7:0] ADDR_SLOT_HIGH = 8'h12;
	localparam logic [7:0] ADDR_TEMP_WHOLE = 8'h1f;
	localparam logic [7:0] ADDR_TEMP_PART = 8'h20;
	localparam logic [7:0] ADDR_TEMP_TRIG = 8'h21;
	localparam logic [7:0] ADDR_SAMPLE_CFG = 8'h0a;
	localparam logic [7:0] ADDR_MODE_CFG = 8'h09;
	// Reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// Field positions
	localparam int SLOT_LO_POS = 0;
	localparam int SLOT_HI_POS = 4;
	localparam int RATE_POS = 2;
	localparam int WIDTH_POS = 0;
	localparam int TRIG_POS = 0;
	// Slot selector codes and mode codes
	localparam logic [2:0] SEL_OFF = 3'h0;
	localparam logic [2:0] SEL_RED = 3'h1;
	localparam logic [2:0] SEL_IR = 3'h2;
	localparam logic [2:0] SEL_GREEN = 3'h3;
	localparam logic [2:0] SEL_DARK = 3'h4;
	localparam logic [2:0] MODE_MULTI = 3'h7;
	localparam logic [2:0] MODE_HEART = 3'h2;
	// Highest rate codes per pulse width (SpO2 and heart-rate tables)
	localparam logic [2:0] SPO2_MAX_RATE [4] = '{3'h7, 3'h6, 3'h5, 3'h4};
	localparam logic [2:0] HR_MAX_RATE [4] = '{3'h7, 3'h6, 3'h6, 3'h5};
	localparam logic [4:0] BASE_RESOLUTION = 5'h0f;
	// Step of drive current in microamps
	localparam int DRIVE_STEP_UA = 200;
	// Time of one die temperature conversion, and its cycle count at 125 MHz
	localparam int TEMP_CONV_US = 30;
	localparam int CLK_MHZ = 125;
	localparam int TEMP_CONV_CYCLES = TEMP_CONV_US * CLK_MHZ;
	// Time of one slot's conversion in microseconds
	localparam int SLOT_US = 69;
	localparam int SLOT_CYCLES = SLOT_US * CLK_MHZ;
	localparam int RESULT_W = 24;
	localparam int FIFO_DEPTH = 8;
endpackage : lst_pkg

// >>> logic/lst_stream_if.sv
// Interface carrying one stream of slot results between modules
`timescale 1ns/1ns
interface lst_stream_if #(parameter int WIDTH = 24);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface : lst_stream_if

// >>> logic/lst_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
module lst_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic srst,
	lst_stream_if.sink inSide,
	lst_stream_if.source outSide
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0] wrPtr_reg;
	logic [AW-1:0] rdPtr_reg;
	logic [AW:0] count_reg;
	wire doWrite;
	wire doRead;
	////////////////////////////////////////////////////////////////////////
	// Handshakes; full and empty come straight from the count
	assign inSide.ready = (count_reg != (AW+1)'(DEPTH));
	assign outSide.valid = (count_reg != '0);
	assign outSide.data = store[rdPtr_reg];
	assign doWrite = inSide.valid && inSide.ready;
	assign doRead = outSide.valid && outSide.ready;
	////////////////////////////////////////////////////////////////////////
	// Storage and pointers
	always_ff @(posedge clk_sys)
	begin
		if (doWrite)
			store[wrPtr_reg] <= inSide.data;
		if (srst)
		begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (doWrite)
				wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
			if (doRead)
				rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
			count_reg <= count_reg + (AW+1)'(doWrite) - (AW+1)'(doRead);
		end
	end
endmodule : lst_fifo

// >>> test/lst_ctrl_properties.sv
// Port-level checker of the LED slot and die temperature control block
`timescale 1ns/1ns
module lst_ctrl_checker #(
	parameter int TEMP_CYCLES = 4,
	parameter int SLOT_CYCLES = 3
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic regWrite,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWriteData,
	input wire logic [7:0] regReadData,
	input wire logic [7:0] redDriveLevel,
	input wire logic [7:0] infraredDriveLevel,
	input wire logic [7:0] greenADriveLevel,
	input wire logic [7:0] greenBDriveLevel,
	input wire logic [15:0] redCurrentUa,
	input wire logic [4:0] adcResolution,
	input wire logic slotBusy,
	input wire logic tempReady,
	input wire logic [23:0] resultData,
	input wire logic resultValid,
	input wire logic resultReady
);
	localparam int TEMP_DLY = TEMP_CYCLES + 1;
	logic [15:0] busyRunReg;
	logic [1:0] widthReg;
	wire trigTaken;
	wire cfgWrite;
	wire [31:0] allLevels;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	////////////////////////////////////////////////////////////////////////////////
	// A trigger counts only when the enable bit reads clear, since a retrigger is refused
	assign trigTaken = regWrite && regAddr == lst_pkg::ADDR_TEMP_TRIG && regWriteData[0]
		&& !regReadData[0];
	assign cfgWrite = regWrite && regAddr == lst_pkg::ADDR_SAMPLE_CFG;
	assign allLevels = {redDriveLevel, infraredDriveLevel, greenADriveLevel, greenBDriveLevel};
	// Pulse length counter and last width code written
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			busyRunReg <= 16'h0000;
			widthReg <= 2'h0;
		end
		else
		begin
			busyRunReg <= slotBusy ? busyRunReg + 16'h0001 : 16'h0000;
			if (cfgWrite)
				widthReg <= regWriteData[1:0];
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	property p_red_current;
		redDriveLevel != 8'h00 |-> redCurrentUa == {8'h00, redDriveLevel} * 16'h00c8;
	endproperty
	a_red_current: assert property (p_red_current) else $error("red current off");
	property p_dark_idle;
		!slotBusy |-> allLevels == 32'h00000000;
	endproperty
	a_dark_idle: assert property (p_dark_idle) else $error("LED driven outside slot");
	property p_one_led;
		$countones({redDriveLevel != 8'h00, infraredDriveLevel != 8'h00,
			(greenADriveLevel | greenBDriveLevel) != 8'h00}) <= 1;
	endproperty
	a_one_led: assert property (p_one_led) else $error("two LEDs in one slot");
	property p_resolution;
		cfgWrite |=> adcResolution == 5'h0f + {3'h0, widthReg};
	endproperty
	a_resolution: assert property (p_resolution) else $error("resolution wrong");
	property p_temp_answer;
		trigTaken |-> ##TEMP_DLY tempReady;
	endproperty
	a_temp_answer: assert property (p_temp_answer) else $error("no ready in time");
	property p_temp_pulse;
		tempReady |=> !tempReady;
	endproperty
	a_temp_pulse: assert property (p_temp_pulse) else $error("ready too long");
	property p_fifo_hold;
		resultValid && !resultReady |=> resultValid && $stable(resultData);
	endproperty
	a_fifo_hold: assert property (p_fifo_hold) else $error("result word lost");
	property p_slot_len;
		$fell(slotBusy) |-> busyRunReg == SLOT_CYCLES;
	endproperty
	a_slot_len: assert property (p_slot_len) else $error("slot pulse length");
endmodule : lst_ctrl_checker

bind lst_ctrl lst_ctrl_checker #(.TEMP_CYCLES(TEMP_CYCLES), .SLOT_CYCLES(SLOT_CYCLES)) u_checker (
	.clk_sys, .srst, .regWrite, .regAddr, .regWriteData, .regReadData, .redDriveLevel,
	.infraredDriveLevel, .greenADriveLevel, .greenBDriveLevel, .redCurrentUa,
	.adcResolution, .slotBusy, .tempReady, .resultData, .resultValid, .resultReady
);

// >>> test/lst_front_model.sv
// Behavioural model of the optical front end that hands slot results to the block
`timescale 1ns/1ns
module lst_front_model (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic slotBusy,
	output logic [23:0] adcResult
);
	logic busyReg;
	logic [7:0] slotCountReg;
	// A fresh word per pulse, so every stored result names the pulse that made it
	always_ff @(posedge clk_sys)
	begin
		busyReg <= slotBusy;
		if (srst)
		begin
			slotCountReg <= 8'h00;
			adcResult <= 24'h000000;
		end
		else if (slotBusy && !busyReg)
		begin
			slotCountReg <= slotCountReg + 8'h01;
			adcResult <= {8'hc3, slotCountReg, ~slotCountReg};
		end
	end
endmodule : lst_front_model

// >>> test/lst_ctrl_tb_top.sv
// Self-checking bench of the LED slot and die temperature control block
`timescale 1ns/1ns
module lst_ctrl_tb_top;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic regWrite = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWriteData = 8'h00;
	logic sampleStart = 1'b0;
	logic resultReady = 1'b0;
	logic [15:0] tempSensorCode = 16'h0000;
	logic [7:0] regReadData, redDriveLevel, infraredDriveLevel, greenADriveLevel;
	logic [7:0] greenBDriveLevel;
	logic [23:0] adcResult, resultData;
	logic [15:0] redCurrentUa;
	logic [4:0] adcResolution;
	logic slotBusy, tempReady, resultValid;
	logic [7:0] lvl [4];
	logic [7:0] nSlot = 8'h00;
	logic [31:0] expQ [$];
	int nErrors = 0;
	int nCompared = 0;
	localparam logic [7:0] REGS [9] = '{lst_pkg::ADDR_RED_LEVEL, lst_pkg::ADDR_IR_LEVEL,
		lst_pkg::ADDR_GREEN_A_LEVEL, lst_pkg::ADDR_GREEN_B_LEVEL, lst_pkg::ADDR_SLOT_LOW,
		lst_pkg::ADDR_SLOT_HIGH, lst_pkg::ADDR_TEMP_WHOLE, lst_pkg::ADDR_TEMP_PART,
		lst_pkg::ADDR_TEMP_TRIG};
	always #4 clk_sys = ~clk_sys;
	// Short counts keep each conversion and slot a few cycles long
	lst_ctrl #(.TEMP_CYCLES(4), .SLOT_CYCLES(3), .FIFO_DEPTH(8)) DUT (
		.clk_sys, .srst, .regWrite, .regAddr, .regWriteData, .regReadData, .sampleStart,
		.adcResult, .tempSensorCode, .redDriveLevel, .infraredDriveLevel, .greenADriveLevel,
		.greenBDriveLevel, .redCurrentUa, .adcResolution, .slotBusy, .tempReady, .resultData,
		.resultValid, .resultReady
	);
	lst_front_model u_front (.clk_sys, .srst, .slotBusy, .adcResult);
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic conclude;
		if (nErrors == 0 && nCompared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWrite <= 1'b1;
		regAddr <= a;
		regWriteData <= d;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		@(negedge clk_sys);
		d = regReadData;
	endtask : rd
	// Highest rate code per width; heart-rate mode is the looser table
	function automatic logic [2:0] cap(input logic hr, input logic [1:0] w);
		if (hr)
			return (w == 2'h0) ? 3'h7 : (w == 2'h3) ? 3'h5 : 3'h6;
		return 3'h7 - {1'b0, w};
	endfunction : cap
	function automatic logic [31:0] drv(input logic [2:0] s);
		return {s == 3'h1 ? lvl[0] : 8'h00, s == 3'h2 ? lvl[1] : 8'h00,
			s == 3'h3 ? lvl[2] : 8'h00, s == 3'h3 ? lvl[3] : 8'h00};
	endfunction : drv
	// Runs one sample and checks each pulse's drive against its selector
	task automatic run_sample(input logic [2:0] s [4], input logic live);
		int k;
		logic prev;
		logic [2:0] act [$];
		k = 0;
		prev = 1'b0;
		for (int i = 0; i < 4; i++)
			if (live && s[i] != 3'h0)
				act.push_back(s[i]);
		wr(lst_pkg::ADDR_SLOT_LOW, {1'b0, s[1], 1'b0, s[0]});
		wr(lst_pkg::ADDR_SLOT_HIGH, {1'b0, s[3], 1'b0, s[2]});
		@(posedge clk_sys);
		sampleStart <= 1'b1;
		@(posedge clk_sys);
		sampleStart <= 1'b0;
		repeat (60)
		begin
			@(negedge clk_sys);
			if (slotBusy === 1'b1 && !prev)
			begin
				if (k < act.size())
					chk("drive", allLv(), drv(act[k]));
				expQ.push_back({8'h00, 8'hc3, nSlot, ~nSlot});
				nSlot++;
				k++;
			end
			prev = slotBusy;
		end
		chk("slots", 32'(k), 32'(act.size()));
	endtask : run_sample
	function automatic logic [31:0] allLv();
		return {redDriveLevel, infraredDriveLevel, greenADriveLevel, greenBDriveLevel};
	endfunction : allLv
	// Pops with random stalls; the stored order must match pulse order
	task automatic drain;
		for (int c = 0; c < 400 && expQ.size() > 0; c++)
		begin
			// Head word is settled mid-cycle; the pop itself lands at the next rising edge
			@(negedge clk_sys);
			if (resultValid === 1'b1 && resultReady === 1'b1)
				chk("result", {8'h00, resultData}, expQ.pop_front());
			@(posedge clk_sys);
			resultReady <= (expQ.size() > 0) ? 1'($urandom_range(0, 1)) : 1'b0;
		end
		if (expQ.size() > 0)
		begin
			nErrors++;
			conclude();
		end
		@(negedge clk_sys);
		chk("empty", 32'(resultValid), 32'h0);
	endtask : drain
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (100000) @(posedge clk_sys);
		nErrors++;
		conclude();
	end
	initial
	begin
		logic [7:0] r;
		logic [2:0] s [4];
		logic [15:0] code;
		int n;
		void'($urandom(32'h7c423086));
		repeat (12) @(posedge clk_sys);
		srst <= 1'b0;
		foreach (REGS[i])
		begin
			rd(REGS[i], r);
			chk("reset", 32'(r), 32'h0);
		end
		for (int i = 0; i < 4; i++)
		begin
			lvl[i] = 8'($urandom_range(1, 255));
			wr(REGS[i], lvl[i]);
			rd(REGS[i], r);
			chk("level", 32'(r), 32'(lvl[i]));
		end
		chk("current", 32'(redCurrentUa), 32'(lvl[0]) * 32'h000000c8);
		wr(8'h13, 8'ha5);
		rd(8'h13, r);
		chk("unmapped", 32'(r), 32'h0);
		// Ask for the top rate at every width in both modes
		for (int m = 0; m < 2; m++)
			for (int w = 0; w < 4; w++)
			begin
				wr(lst_pkg::ADDR_MODE_CFG, m[0] ? 8'h02 : 8'h03);
				wr(lst_pkg::ADDR_SAMPLE_CFG, 8'(w));
				wr(lst_pkg::ADDR_SAMPLE_CFG, 8'(w) | 8'h1c);
				rd(lst_pkg::ADDR_SAMPLE_CFG, r);
				chk("rate", 32'(r), 32'({cap(m[0], w[1:0]), w[1:0]}));
				chk("resolution", 32'(adcResolution), 32'(5'h0f + 5'(w)));
			end
		// Extremes of the signed range, then a random code; the retrigger is refused
		for (int t = 0; t < 3; t++)
		begin
			code = (t == 0) ? 16'h07f8 : (t == 1) ? 16'h0805 : 16'($urandom);
			@(posedge clk_sys);
			tempSensorCode <= code;
			wr(lst_pkg::ADDR_TEMP_TRIG, 8'h01);
			wr(lst_pkg::ADDR_TEMP_TRIG, 8'h01);
			n = 0;
			repeat (20)
			begin
				@(negedge clk_sys);
				n += (tempReady === 1'b1);
			end
			chk("conversions", 32'(n), 32'h1);
			rd(lst_pkg::ADDR_TEMP_TRIG, r);
			chk("enable", 32'(r), 32'h0);
			rd(lst_pkg::ADDR_TEMP_WHOLE, r);
			chk("whole", 32'(r), 32'(code[11:4]));
			rd(lst_pkg::ADDR_TEMP_PART, r);
			chk("fraction", 32'(r), 32'(code[3:0]));
		end
		// Two full samples fill the buffer before it is drained
		wr(lst_pkg::ADDR_MODE_CFG, 8'h07);
		wr(lst_pkg::ADDR_SAMPLE_CFG, 8'h00);
		run_sample('{3'h1, 3'h2, 3'h3, 3'h4}, 1'b1);
		for (int i = 0; i < 4; i++)
			s[i] = 3'($urandom_range(1, 4));
		run_sample(s, 1'b1);
		chk("full", 32'(resultValid), 32'h1);
		drain();
		for (int j = 0; j < 6; j++)
		begin
			n = $urandom_range(1, 4);
			for (int i = 0; i < 4; i++)
				s[i] = (i < n) ? 3'($urandom_range(1, 4)) : 3'h0;
			run_sample(s, 1'b1);
			drain();
		end
		wr(lst_pkg::ADDR_MODE_CFG, 8'h03);
		run_sample(s, 1'b0);
		expQ.delete();
		conclude();
	end
endmodule : lst_ctrl_tb_top
